// >>> core/somsel_pkg.sv
// Constants, types and register layout of the startup operation mode selector.
package somsel_pkg;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] ADR_OPSEL = 8'h00;
	localparam logic [7:0] ADR_START = 8'h04;
	localparam logic [7:0] ADR_CTRL = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0C;

	// ==========================================================
	// Values after reset
	localparam logic [7:0] RST_OPSEL = 8'h00;
	localparam logic [7:0] RST_START = 8'h00;
	localparam logic RST_SWITCH_EN = 1'b0;

	// ==========================================================
	// Operation mode select settings
	localparam logic [7:0] OPSEL_ALL = 8'h00;
	localparam logic [7:0] OPSEL_PANEL = 8'h01;
	localparam logic [7:0] OPSEL_TERM_NET = 8'h02;
	localparam logic [7:0] OPSEL_COMB_A = 8'h03;
	localparam logic [7:0] OPSEL_COMB_B = 8'h04;
	localparam logic [7:0] OPSEL_RUN_SWITCH = 8'h06;
	localparam logic [7:0] OPSEL_STOP_GATED = 8'h07;

	// ==========================================================
	// Startup mode select settings
	localparam logic [7:0] START_AS_OPSEL = 8'h00;
	localparam logic [7:0] START_NET = 8'h01;
	localparam logic [7:0] START_PANEL_NET = 8'h0A;

	// ==========================================================
	// Control register fields
	localparam int CTRL_TERM_SW_EN_BIT = 0;
	localparam int CTRL_PANEL_SW_EN_BIT = 1;
	localparam int CTRL_REQ_BIT = 2;
	localparam int CTRL_REQ_LSB = 4;

	// ==========================================================
	// Status register fields
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_TERM_NET_BIT = 2;
	localparam int STAT_TERM_PANEL_BIT = 3;
	localparam int STAT_PANEL_NET_BIT = 4;
	localparam int STAT_RUN_OK_BIT = 5;
	localparam int STAT_FORCE_BIT = 6;
	localparam int STAT_REFUSED_BIT = 7;
	localparam int STAT_RUNNING_BIT = 8;
	localparam int STAT_CMD_SRC_BIT = 9;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		MODE_TERMINAL = 2'h0,
		MODE_PANEL = 2'h1,
		MODE_NETWORK = 2'h2,
		MODE_COMBINED = 2'h3
	} somselMode_t;

	typedef enum logic [1:0] {
		ST_INIT = 2'h0,
		ST_HOLD = 2'h1
	} somselState_t;

	typedef struct packed {
		somselMode_t initMode;
		logic allowTermNet;
		logic allowTermPanel;
		logic allowPanelNet;
		logic changeWhileRunning;
		logic forceTerminal;
	} somselPolicy_t;

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] sel;
	} somselRegWr_t;

endpackage : somsel_pkg

// >>> core/somsel_policy.sv
// Decodes the two setting fields into start mode and change permissions.
`timescale 1ns/1ns
`default_nettype none
module somsel_policy import somsel_pkg::*; (
	input wire logic [7:0] opSel,
	input wire logic [7:0] startSel,
	input wire logic outputStopInput,
	output somselPolicy_t policy
);

	// ==========================================================
	// Setting decode; unknown values fall back to terminal with no changes
	always_comb begin
		policy.initMode = MODE_TERMINAL;
		policy.allowTermNet = 1'b0;
		policy.allowTermPanel = 1'b0;
		policy.allowPanelNet = 1'b0;
		policy.changeWhileRunning = 1'b0;
		policy.forceTerminal = 1'b0;
		case (opSel)
			OPSEL_ALL, OPSEL_RUN_SWITCH: begin
				policy.changeWhileRunning = (opSel == OPSEL_RUN_SWITCH); // [R8] [R13]
				if (startSel == START_PANEL_NET) begin
					policy.initMode = MODE_NETWORK; // [R11] [R13]
					policy.allowPanelNet = 1'b1; // [R11]
				end else begin
					// Panel and network never pair directly here
					policy.initMode = (startSel == START_NET) ? MODE_NETWORK : MODE_TERMINAL; // [R3] [R10]
					policy.allowTermNet = 1'b1; // [R3] [R4]
					policy.allowTermPanel = 1'b1; // [R3] [R4]
				end
			end
			OPSEL_PANEL: begin
				policy.initMode = MODE_PANEL; // [R5] [R14]
			end
			OPSEL_TERM_NET: begin
				if (startSel == START_PANEL_NET) begin
					policy.initMode = MODE_NETWORK; // [R12]
				end else begin
					policy.initMode = (startSel == START_NET) ? MODE_NETWORK : MODE_TERMINAL; // [R6] [R10]
					policy.allowTermNet = 1'b1; // [R6]
				end
			end
			OPSEL_COMB_A, OPSEL_COMB_B: begin
				policy.initMode = MODE_COMBINED; // [R7] [R14]
			end
			OPSEL_STOP_GATED: begin
				if (outputStopInput) begin
					// Startup field 10 acts as field 0 for this setting
					policy.initMode = (startSel == START_NET) ? MODE_NETWORK : MODE_TERMINAL; // [R9] [R10] [R14]
					policy.allowTermNet = 1'b1; // [R9]
					policy.allowTermPanel = 1'b1; // [R9]
				end else begin
					policy.forceTerminal = 1'b1; // [R9]
				end
			end
			default: begin
				policy.initMode = MODE_TERMINAL;
			end
		endcase
	end

endmodule : somsel_policy
`default_nettype wire

// >>> core/somsel_top.sv
// Startup operation mode selector: settings, mode state and change arbitration.
//
// Contract
// [R1] Pick start mode at power-up, restore, reset
// [R2] Mode setting writes accepted only while stopped
// [R3] Field 0, select 0: terminal, all switching
// [R4] No direct panel-network change outside field 10
// [R5] Select 1: panel mode, no changes
// [R6] Select 2: terminal start, terminal-network only
// [R7] Select 3 or 4: combined mode, fixed
// [R8] Select 6: changes allowed while running
// [R9] Select 7: output-stop gates changes, else terminal
// [R10] Field 1: network start where allowed
// [R11] Field 10, select 0: network, panel-network while stopped
// [R12] Field 10, select 2: fixed network mode
// [R13] Field 10, select 6: panel-network while running
// [R14] Field 10, other selects act as field 0
// [R15] Panel key or panel switch requests panel-network
// [R16] Network mode enables link writes and commands
// [R17] Panel switch on panel, off network
// [R18] Select, stop, terminal, panel, source, field priority; the command source switch is only read into status here
// [R19] Start mode registered one cycle after reset
//
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module somsel_top import somsel_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic powerRestore,
	input wire logic motorRunning,
	input wire logic outputStopInput,
	input wire logic netPanelSwitchInput,
	input wire logic netTerminalSwitchInput,
	input wire logic commandSourceSwitchInput,
	input wire logic panelModeKey,
	output logic [1:0] operationMode,
	output logic netCommandEnable
);

	// ==========================================================
	// Declarations
	somselRegWr_t regWr;
	somselPolicy_t policy;
	somselMode_t mode_q;
	somselMode_t reqTarget;
	somselState_t state_q;
	logic [31:0] rdData;
	logic [7:0] opSel_q;
	logic [7:0] startSel_q;
	logic termSwEn_q;
	logic panelSwEn_q;
	logic refused_q;
	logic keyPrev_q;
	logic netCmd_q;
	logic wrOp;
	logic wrStart;
	logic wrCtrl;
	logic wrStatus;
	logic opAccept;
	logic startAccept;
	logic anyReject;
	logic keyPress;
	logic swReq;
	logic reqValid;
	logic changeOk;

	// ==========================================================
	// Helper functions
	function automatic logic validOpSel(input logic [7:0] v);
		validOpSel = (v == OPSEL_ALL) || (v == OPSEL_PANEL) || (v == OPSEL_TERM_NET) ||
			(v == OPSEL_COMB_A) || (v == OPSEL_COMB_B) || (v == OPSEL_RUN_SWITCH) ||
			(v == OPSEL_STOP_GATED);
	endfunction : validOpSel

	function automatic logic validStart(input logic [7:0] v);
		validStart = (v == START_AS_OPSEL) || (v == START_NET) || (v == START_PANEL_NET);
	endfunction : validStart

	// Unordered pair check against the current permission set
	function automatic logic pairAllowed(input somselPolicy_t p, input somselMode_t a,
		input somselMode_t b);
		logic tn;
		logic tp;
		logic pn;
		tn = ((a == MODE_TERMINAL) && (b == MODE_NETWORK)) ||
			((a == MODE_NETWORK) && (b == MODE_TERMINAL));
		tp = ((a == MODE_TERMINAL) && (b == MODE_PANEL)) ||
			((a == MODE_PANEL) && (b == MODE_TERMINAL));
		pn = ((a == MODE_PANEL) && (b == MODE_NETWORK)) ||
			((a == MODE_NETWORK) && (b == MODE_PANEL));
		pairAllowed = (tn && p.allowTermNet) || (tp && p.allowTermPanel) ||
			(pn && p.allowPanelNet);
	endfunction : pairAllowed

	// ==========================================================
	// Bus front end and setting decoder
	somsel_wb_slave u_wb (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i),
		.rdData(rdData),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.regWr(regWr)
	);

	somsel_policy u_policy (
		.opSel(opSel_q),
		.startSel(startSel_q),
		.outputStopInput(outputStopInput),
		.policy(policy)
	);

	// ==========================================================
	// Write address decode; all writable fields live in byte lane 0
	always_comb begin
		wrOp = 1'b0;
		wrStart = 1'b0;
		wrCtrl = 1'b0;
		wrStatus = 1'b0;
		if (!regWr.valid || !regWr.sel[0]) begin
			wrOp = 1'b0;
		end else if (regWr.addr == ADR_OPSEL) begin
			wrOp = 1'b1;
		end else if (regWr.addr == ADR_START) begin
			wrStart = 1'b1;
		end else if (regWr.addr == ADR_CTRL) begin
			wrCtrl = 1'b1;
		end else if (regWr.addr == ADR_STATUS) begin
			wrStatus = 1'b1;
		end
	end

	// Setting writes only land while the motor is stopped
	assign opAccept = wrOp && !motorRunning && validOpSel(regWr.data[7:0]); // [R2]
	assign startAccept = wrStart && !motorRunning && validStart(regWr.data[7:0]); // [R2]
	assign anyReject = (wrOp && !opAccept) || (wrStart && !startAccept);

	// ==========================================================
	// Setting registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			opSel_q <= RST_OPSEL;
		end else if (opAccept) begin
			opSel_q <= regWr.data[7:0]; // [R2]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			startSel_q <= RST_START;
		end else if (startAccept) begin
			startSel_q <= regWr.data[7:0]; // [R2]
		end
	end

	// Switch input enables, written at any time
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			termSwEn_q <= RST_SWITCH_EN;
			panelSwEn_q <= RST_SWITCH_EN;
		end else if (wrCtrl) begin
			termSwEn_q <= regWr.data[CTRL_TERM_SW_EN_BIT];
			panelSwEn_q <= regWr.data[CTRL_PANEL_SW_EN_BIT];
		end
	end

	// Sticky refusal flag; a new refusal beats a same-cycle clear
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			refused_q <= 1'b0;
		end else if (anyReject) begin
			refused_q <= 1'b1; // [R2]
		end else if (wrStatus && regWr.data[STAT_REFUSED_BIT]) begin
			refused_q <= 1'b0;
		end
	end

	// ==========================================================
	// Change requests
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			keyPrev_q <= 1'b0;
		end else begin
			keyPrev_q <= panelModeKey;
		end
	end

	// One request per key press, not per cycle held
	assign keyPress = panelModeKey && !keyPrev_q; // [R15]
	assign swReq = wrCtrl && regWr.data[CTRL_REQ_BIT];

	// Terminal switch outranks panel switch, which outranks the key
	always_comb begin
		reqValid = 1'b0;
		reqTarget = mode_q;
		if (termSwEn_q && policy.allowTermNet &&
			((mode_q == MODE_TERMINAL) || (mode_q == MODE_NETWORK))) begin
			reqValid = 1'b1; // [R18]
			reqTarget = netTerminalSwitchInput ? MODE_NETWORK : MODE_TERMINAL;
		end else if (panelSwEn_q && policy.allowPanelNet) begin
			reqValid = 1'b1; // [R18] [R15]
			reqTarget = netPanelSwitchInput ? MODE_PANEL : MODE_NETWORK; // [R17]
		end else if (keyPress) begin
			reqValid = 1'b1; // [R15]
			if (policy.allowPanelNet) begin
				reqTarget = (mode_q == MODE_PANEL) ? MODE_NETWORK : MODE_PANEL;
			end else begin
				reqTarget = (mode_q == MODE_PANEL) ? MODE_TERMINAL : MODE_PANEL;
			end
		end else if (swReq) begin
			reqValid = 1'b1;
			reqTarget = somselMode_t'(regWr.data[CTRL_REQ_LSB +: 2]);
		end
	end

	// Running blocks a change unless the setting allows it
	assign changeOk = reqValid && (reqTarget != mode_q) &&
		pairAllowed(policy, mode_q, reqTarget) && // [R4] [R5] [R7] [R12]
		(policy.changeWhileRunning || !motorRunning); // [R8] [R11] [R13]

	// ==========================================================
	// Mode state: load start mode, then hold until a permitted change
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= ST_INIT; // [R1]
			mode_q <= MODE_TERMINAL;
		end else begin
			case (state_q)
				ST_INIT: begin
					mode_q <= policy.initMode; // [R1] [R19]
					state_q <= ST_HOLD;
				end
				ST_HOLD: begin
					// Restore or new setting re-runs the start decision
					if (powerRestore || opAccept || startAccept) begin
						state_q <= ST_INIT; // [R1]
					end else if (policy.forceTerminal) begin
						mode_q <= MODE_TERMINAL; // [R9] [R18]
					end else if (changeOk) begin
						mode_q <= reqTarget; // [R19]
					end
				end
				default: begin
					state_q <= ST_INIT;
				end
			endcase
		end
	end

	// Link side may write parameters and issue commands in network mode
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			netCmd_q <= 1'b0;
		end else begin
			netCmd_q <= (mode_q == MODE_NETWORK); // [R16]
		end
	end

	assign operationMode = mode_q;
	assign netCommandEnable = netCmd_q;

	// ==========================================================
	// Read mux; unmapped addresses read as zero
	always_comb begin
		rdData = 32'h0000_0000;
		if (wb_adr_i == ADR_OPSEL) begin
			rdData[7:0] = opSel_q;
		end else if (wb_adr_i == ADR_START) begin
			rdData[7:0] = startSel_q;
		end else if (wb_adr_i == ADR_CTRL) begin
			rdData[CTRL_TERM_SW_EN_BIT] = termSwEn_q;
			rdData[CTRL_PANEL_SW_EN_BIT] = panelSwEn_q;
		end else if (wb_adr_i == ADR_STATUS) begin
			rdData[STAT_MODE_LSB +: 2] = mode_q;
			rdData[STAT_TERM_NET_BIT] = policy.allowTermNet;
			rdData[STAT_TERM_PANEL_BIT] = policy.allowTermPanel;
			rdData[STAT_PANEL_NET_BIT] = policy.allowPanelNet;
			rdData[STAT_RUN_OK_BIT] = policy.changeWhileRunning;
			rdData[STAT_FORCE_BIT] = policy.forceTerminal;
			rdData[STAT_REFUSED_BIT] = refused_q;
			rdData[STAT_RUNNING_BIT] = motorRunning;
			rdData[STAT_CMD_SRC_BIT] = commandSourceSwitchInput;
		end
	end

endmodule : somsel_top
`default_nettype wire

// >>> core/somsel_wb_slave.sv
// Classic Wishbone slave front end with registered acknowledge and read data.
`timescale 1ns/1ns
`default_nettype none
module somsel_wb_slave import somsel_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] rdData,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output somselRegWr_t regWr
);

	logic ack_q;
	logic [31:0] dat_q;
	logic newReq;

	// ==========================================================
	// One wait state, then ack for exactly one cycle
	assign newReq = wb_cyc_i && wb_stb_i && !ack_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= newReq;
		end
	end

	// Read data captured with the ack so it is stable while ack is high
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dat_q <= 32'h0000_0000;
		end else if (newReq) begin
			dat_q <= rdData;
		end
	end

	// Write commits on the edge where the master sees ack
	always_comb begin
		regWr.valid = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
		regWr.addr = wb_adr_i;
		regWr.data = wb_dat_i;
		regWr.sel = wb_sel_i;
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

endmodule : somsel_wb_slave
`default_nettype wire

// >>> verification/somsel_partner.sv
// Panel key, terminal inputs and supply monitor facing the selector.
`timescale 1ns/1ns
`default_nettype none
module somsel_partner (
	input wire logic clk_sys,
	output var logic motorRunning,
	output var logic outputStopInput,
	output var logic netPanelSwitchInput,
	output var logic netTerminalSwitchInput,
	output var logic commandSourceSwitchInput,
	output var logic panelModeKey,
	output var logic powerRestore
);
	// Stopped and idle at time zero
	initial begin
		{motorRunning, outputStopInput, netPanelSwitchInput} = 3'h0;
		{netTerminalSwitchInput, commandSourceSwitchInput, panelModeKey, powerRestore} = 4'h0;
	end
	// Key press, then a low cycle so the next press is a new edge
	task automatic press();
		panelModeKey <= 1'b1;
		@(posedge clk_sys);
		panelModeKey <= 1'b0;
		@(posedge clk_sys);
	endtask : press
	// Levels change together just after an edge
	task automatic lvl(input logic r, input logic s, input logic np, input logic nt,
		input logic cs);
		{motorRunning, outputStopInput, netPanelSwitchInput} <= {r, s, np};
		{netTerminalSwitchInput, commandSourceSwitchInput} <= {nt, cs};
		@(posedge clk_sys);
	endtask : lvl
	// Supply comes back: one-cycle flag
	task automatic restore();
		powerRestore <= 1'b1;
		@(posedge clk_sys);
		powerRestore <= 1'b0;
		@(posedge clk_sys);
	endtask : restore
endmodule : somsel_partner
`default_nettype wire

// >>> verification/somsel_properties.sv
// Port-level checker of mode selection and bus answers.
`timescale 1ns/1ns
`default_nettype none
module somsel_properties import somsel_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_ack_o,
	input wire logic powerRestore,
	input wire logic motorRunning,
	input wire logic outputStopInput,
	input wire logic [1:0] operationMode,
	input wire logic netCommandEnable
);
	// ==========================================================
	// Shadow of accepted setting writes
	logic [7:0] v;
	logic [7:0] selQ;
	logic [7:0] startQ;
	logic [1:0] calmQ;
	logic wrOk;
	logic wrSel;
	logic wrStart;
	logic calm;
	assign v = wb_dat_i[7:0];
	assign wrOk = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && !motorRunning;
	assign wrSel = wrOk && wb_adr_i == ADR_OPSEL && v < 8'h08 && v != 8'h05;
	assign wrStart = wrOk && wb_adr_i == ADR_START
		&& (v == START_AS_OPSEL || v == START_NET || v == START_PANEL_NET);
	assign calm = calmQ == 2'h3;
	// Refused values never reach the shadow
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			selQ <= RST_OPSEL;
			startQ <= RST_START;
		end else begin
			selQ <= wrSel ? v : selQ;
			startQ <= wrStart ? v : startQ;
		end
	end
	// Settling count, since a new setting takes a cycle to reach the mode
	always_ff @(posedge clk_sys) begin
		if (!rst_n || wrSel || wrStart) begin
			calmQ <= 2'h0;
		end else if (!calm) begin
			calmQ <= calmQ + 2'h1;
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	AST_ACK_WAIT: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	AST_START_TERM: assert property (
		$rose(rst_n) |=> (operationMode == MODE_TERMINAL) [*2])
		else $error("no terminal start");
	AST_NET_CMD: assert property (
		netCommandEnable == ($past(operationMode) == MODE_NETWORK))
		else $error("command gate off mode");
	AST_PANEL_FIXED: assert property (
		calm && selQ == OPSEL_PANEL |-> operationMode == MODE_PANEL)
		else $error("panel mode not held");
	AST_COMB_FIXED: assert property (
		calm && (selQ == OPSEL_COMB_A || selQ == OPSEL_COMB_B) |-> operationMode == MODE_COMBINED)
		else $error("combined mode not held");
	AST_SEL2_NO_PANEL: assert property (
		calm && selQ == OPSEL_TERM_NET |-> operationMode != MODE_PANEL)
		else $error("panel entered");
	AST_FORCE_TERM: assert property (
		calm && selQ == OPSEL_STOP_GATED && !outputStopInput |=> operationMode == MODE_TERMINAL)
		else $error("terminal not forced");
	AST_NO_PANEL_NET: assert property (
		calm && $past(calm) && startQ != START_PANEL_NET && !$past(powerRestore)
		&& !$past(powerRestore, 2) |-> !($past(operationMode) == MODE_PANEL
		&& operationMode == MODE_NETWORK) && !($past(operationMode) == MODE_NETWORK
		&& operationMode == MODE_PANEL))
		else $error("direct panel network step");
	AST_RUN_HOLD: assert property (
		calm && selQ == OPSEL_ALL && motorRunning && !powerRestore && !$past(powerRestore)
		|=> $stable(operationMode))
		else $error("mode changed while running");
endmodule : somsel_properties
bind somsel_top somsel_properties somsel_properties_i (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o, .powerRestore, .motorRunning,
	.outputStopInput, .operationMode, .netCommandEnable);
`default_nettype wire

// >>> verification/startup_operation_mode_selector_tb.sv
// Self-checking bench of the startup mode selector.
`timescale 1ns/1ns
`default_nettype none
module startup_operation_mode_selector_tb import somsel_pkg::*;;
	// ==========================================================
	// Wiring
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic powerRestore, motorRunning, outputStopInput, panelModeKey;
	logic netPanelSwitchInput, netTerminalSwitchInput, commandSourceSwitchInput;
	logic [1:0] operationMode;
	logic netCommandEnable;
	int mismatches = 0;
	int samplesChecked = 0;
	int cycles = 0;
	somsel_top somsel_top_i (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .powerRestore, .motorRunning,
		.outputStopInput, .netPanelSwitchInput, .netTerminalSwitchInput,
		.commandSourceSwitchInput, .panelModeKey, .operationMode, .netCommandEnable);
	somsel_partner somsel_partner_i (.clk_sys, .motorRunning, .outputStopInput,
		.netPanelSwitchInput, .netTerminalSwitchInput, .commandSourceSwitchInput,
		.panelModeKey, .powerRestore);
	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	// ==========================================================
	// Shared tasks
	task automatic complete_run();
		$display("compared %0d mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Classic cycle held until ack is sampled, then one idle cycle
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk_sys);
		// Without an ack, only the hang guard ends this wait
		while (wb_ack_o !== 1'b1) begin
			@(posedge clk_sys);
		end
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		@(posedge clk_sys);
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(a, 1'b1, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(a, 1'b0, 32'h0, q);
		chk(q, e);
	endtask : rd
	// Startup field first, since each accepted write restarts the choice
	task automatic cfg(input logic [7:0] st, input logic [7:0] sl);
		wr(ADR_START, {24'h0, st});
		wr(ADR_OPSEL, {24'h0, sl});
	endtask : cfg
	task automatic key();
		somsel_partner_i.press();
	endtask : key
	task automatic lv(input logic r, input logic s, input logic np, input logic nt,
		input logic cs);
		somsel_partner_i.lvl(r, s, np, nt, cs);
	endtask : lv
	// Settle, then mode and the link command gate together
	task automatic mode_is(input somselMode_t m);
		repeat (3) @(posedge clk_sys);
		chk({30'h0, operationMode}, {30'h0, m});
		chk({31'h0, netCommandEnable}, {31'h0, m == MODE_NETWORK});
	endtask : mode_is
	// ==========================================================
	// Scenarios
	task automatic t_all();
		mode_is(MODE_TERMINAL);
		rd(ADR_OPSEL, 32'h0);
		rd(8'h40, 32'h0);
		key();
		mode_is(MODE_PANEL);
		wr(ADR_CTRL, 32'h3);
		lv(0, 0, 0, 1, 0);
		mode_is(MODE_PANEL);
		key();
		mode_is(MODE_NETWORK);
		lv(0, 0, 1, 1, 0);
		mode_is(MODE_NETWORK);
		lv(0, 0, 0, 0, 0);
		mode_is(MODE_TERMINAL);
		wr(ADR_CTRL, 32'h0);
		// Software request: allowed pair, barred pair, way back
		wr(ADR_CTRL, 32'h14);
		mode_is(MODE_PANEL);
		wr(ADR_CTRL, 32'h24);
		mode_is(MODE_PANEL);
		wr(ADR_CTRL, 32'h04);
		mode_is(MODE_TERMINAL);
	endtask : t_all
	// A running write is dropped and flagged; a bad value is dropped; the flag then clears
	task automatic t_refuse();
		lv(1, 0, 0, 0, 1);
		wr(ADR_OPSEL, {24'h0, OPSEL_PANEL});
		rd(ADR_OPSEL, 32'h0);
		key();
		mode_is(MODE_TERMINAL);
		rd(ADR_STATUS, 32'h38C);
		lv(0, 0, 0, 0, 0);
		wr(ADR_OPSEL, 32'h5);
		rd(ADR_OPSEL, 32'h0);
		wr(ADR_STATUS, 32'h80);
		rd(ADR_STATUS, 32'h0C);
	endtask : t_refuse
	task automatic t_fixed();
		cfg(START_AS_OPSEL, OPSEL_PANEL);
		key();
		mode_is(MODE_PANEL);
		cfg(START_PANEL_NET, OPSEL_COMB_B);
		key();
		mode_is(MODE_COMBINED);
		cfg(START_AS_OPSEL, OPSEL_TERM_NET);
		key();
		mode_is(MODE_TERMINAL);
		wr(ADR_CTRL, 32'h1);
		lv(0, 0, 0, 1, 0);
		mode_is(MODE_NETWORK);
		lv(0, 0, 0, 0, 0);
		mode_is(MODE_TERMINAL);
		// An enabled terminal switch outranks the key, so drop it first
		wr(ADR_CTRL, 32'h0);
		cfg(START_AS_OPSEL, OPSEL_RUN_SWITCH);
		lv(1, 0, 0, 0, 0);
		key();
		mode_is(MODE_PANEL);
		lv(0, 0, 0, 0, 0);
	endtask : t_fixed
	// Output-stop gating outranks the terminal switch
	task automatic t_sel7();
		cfg(START_AS_OPSEL, OPSEL_STOP_GATED);
		wr(ADR_CTRL, 32'h1);
		lv(0, 0, 0, 1, 0);
		key();
		mode_is(MODE_TERMINAL);
		lv(0, 1, 0, 1, 0);
		mode_is(MODE_NETWORK);
		lv(0, 1, 0, 0, 0);
		mode_is(MODE_TERMINAL);
		wr(ADR_CTRL, 32'h0);
		key();
		mode_is(MODE_PANEL);
		lv(0, 0, 0, 0, 0);
		mode_is(MODE_TERMINAL);
	endtask : t_sel7
	task automatic t_start1();
		logic [7:0] s [3] = '{OPSEL_ALL, OPSEL_TERM_NET, OPSEL_RUN_SWITCH};
		foreach (s[i]) begin
			cfg(START_NET, s[i]);
			mode_is(MODE_NETWORK);
		end
		wr(ADR_CTRL, 32'h1);
		mode_is(MODE_TERMINAL);
		wr(ADR_CTRL, 32'h0);
		somsel_partner_i.restore();
		mode_is(MODE_NETWORK);
	endtask : t_start1
	task automatic t_field10();
		cfg(START_PANEL_NET, OPSEL_ALL);
		mode_is(MODE_NETWORK);
		key();
		mode_is(MODE_PANEL);
		lv(1, 0, 0, 0, 0);
		key();
		mode_is(MODE_PANEL);
		lv(0, 0, 0, 0, 0);
		cfg(START_PANEL_NET, OPSEL_RUN_SWITCH);
		lv(1, 0, 0, 0, 0);
		key();
		mode_is(MODE_PANEL);
		lv(0, 1, 0, 0, 0);
		cfg(START_PANEL_NET, OPSEL_TERM_NET);
		key();
		mode_is(MODE_NETWORK);
		cfg(START_PANEL_NET, OPSEL_STOP_GATED);
		mode_is(MODE_TERMINAL);
		cfg(START_PANEL_NET, OPSEL_ALL);
		wr(ADR_CTRL, 32'h2);
		lv(0, 0, 1, 0, 0);
		mode_is(MODE_PANEL);
		lv(0, 0, 0, 0, 0);
		mode_is(MODE_NETWORK);
	endtask : t_field10
	// Reset held eight cycles, then every scenario in turn
	initial begin
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		t_all();
		t_refuse();
		t_fixed();
		t_sel7();
		t_start1();
		t_field10();
		complete_run();
	end
endmodule : startup_operation_mode_selector_tb
`default_nettype wire
